// [pdg_pkg.sv]
package pdg_pkg;
  // ==========================================================
  // Bus and map
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_VENDOR_ID = 8'h00;
  localparam logic [7:0] IDX_DEVICE_ID = 8'h02;
  localparam logic [7:0] IDX_DIAG = 8'h93;
  localparam logic [7:0] IDX_CAP_ID = 8'ha0;
  localparam logic [7:0] IDX_CAP_LINK = 8'ha1;
  localparam logic [7:0] IDX_CAP_WORD = 8'ha2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h00;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h01;
  localparam int unsigned FUNC_BIT = 10;
  localparam int unsigned LOCAL_BIT = 11;

  // ==========================================================
  // Diagnostic byte fields
  localparam int unsigned DG_ID_MASK = 7;
  localparam int unsigned DG_FIXED_ONE = 6;
  localparam int unsigned DG_CHG_ROUTE = 5;
  localparam int unsigned DG_DT_DIS = 4;
  localparam int unsigned DG_RETRY_LONG = 3;
  localparam int unsigned DG_CARD_SEL = 2;
  localparam int unsigned DG_HOST_SEL = 1;
  localparam int unsigned DG_ZV_DIS = 0;
  localparam logic [7:0] DIAG_RESET = 8'h60;

  // ==========================================================
  // Capability list
  localparam logic [7:0] CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] CAP_LINK_VALUE = 8'h00;
  localparam logic [15:0] CAP_WORD_RESET = 16'hfe12;
  localparam int unsigned CAP_WAKE_COLD = 15;
  localparam int unsigned CAP_AUX_PWR = 4;
  localparam logic [15:0] ID_MASKED = 16'hffff;

  // ==========================================================
  // Interrupt status layout
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_CHG0 = 0;
  localparam int unsigned IRQ_CHG1 = 1;
  localparam int unsigned IRQ_CARD_DISCARD = 2;
  localparam int unsigned IRQ_HOST_DISCARD = 3;
  localparam int unsigned IRQ_RETRY = 4;

  // ==========================================================
  // Timing counts (in bus-side clocks)
  localparam int unsigned TMR_W = 17;
  localparam logic [TMR_W-1:0] RETRY_SHORT = 17'h0_0010;
  localparam logic [TMR_W-1:0] RETRY_LONG = 17'h0_0040;
  localparam int unsigned DISCARD_SHORT_CLKS = 1024;
  localparam int unsigned DISCARD_LONG_CLKS = 32768;
endpackage

// [pdg_sync.sv]
`timescale 1ns/1ps
module pdg_sync (
  // Clock
  input wire logic core_clk,
  // Level from outside the domain
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_reg;

  // ==========================================================
  // Two-stage synchroniser
  always_ff @(posedge core_clk) begin
    stage1_reg <= async_in;
    sync_out <= stage1_reg;
  end
endmodule

// [pdg_timer.sv]
`timescale 1ns/1ps
module pdg_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic tick_en,
  input wire logic run,
  input wire logic [pdg_pkg::TMR_W-1:0] limit,
  // Result
  output logic expired
);
  import pdg_pkg::*;

  logic [TMR_W-1:0] count_reg;
  logic [TMR_W-1:0] count_next;
  logic last_tick;

  assign count_next = count_reg + 17'h0_0001;
  assign last_tick = tick_en && (count_next >= limit);

  // ==========================================================
  // Counts ticks while run holds; restarts when run drops
  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      count_reg <= '0;
    end else if (last_tick) begin
      count_reg <= '0;
    end else if (tick_en) begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= run && last_tick;
    end
  end
endmodule

// [pdg_diag_pm_regs.sv]
`timescale 1ns/1ps
module pdg_diag_pm_regs #(
  parameter int unsigned DISCARD_SHORT = pdg_pkg::DISCARD_SHORT_CLKS,
  parameter int unsigned DISCARD_LONG = pdg_pkg::DISCARD_LONG_CLKS,
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678 // Arbitrary value
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic global_reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus-side clock enables
  input wire logic host_tick_en,
  input wire logic card_tick_en,
  // Transaction status from the bridge core
  input wire logic target_access_active,
  input wire logic host_dt_pending,
  input wire logic card_dt_pending,
  // Card status change, per function
  input wire logic [1:0] card_change_event,
  input wire logic [1:0] legacy_socket_regs_803_b4,
  input wire logic [3:0] legacy_socket_regs_805_hi0,
  input wire logic [3:0] legacy_socket_regs_805_hi1,
  // Controls to the bridge core
  output logic id_mask_enable,
  output logic deferred_access_off,
  output logic long_retry_window,
  output logic [1:0] zoomed_video_model_disable,
  output logic [1:0] card_change_to_pci,
  output logic retry_terminate,
  output logic host_discard_expired,
  output logic card_discard_expired,
  // Interrupt
  output logic irq
);
  import pdg_pkg::*;

  // ==========================================================
  // Address decode
  function automatic logic is_cfg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] idx);
    is_cfg = !a[LOCAL_BIT] && (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_local(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    is_local = a[LOCAL_BIT] && (a[FUNC_BIT:2] == {1'b0, idx})
               && (a[1:0] == 2'b00);
  endfunction

  logic fn1;
  logic setup_phase;
  logic wr_en;
  logic hit_vendor;
  logic hit_device;
  logic hit_diag;
  logic hit_cap_id;
  logic hit_cap_link;
  logic hit_cap_word;
  logic hit_status;
  logic hit_mask;
  logic hit_any;

  assign fn1 = paddr[FUNC_BIT];
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready && !pslverr;
  assign hit_vendor = is_cfg(paddr, IDX_VENDOR_ID);
  assign hit_device = is_cfg(paddr, IDX_DEVICE_ID);
  assign hit_diag = is_cfg(paddr, IDX_DIAG);
  assign hit_cap_id = is_cfg(paddr, IDX_CAP_ID);
  assign hit_cap_link = is_cfg(paddr, IDX_CAP_LINK);
  assign hit_cap_word = is_cfg(paddr, IDX_CAP_WORD);
  assign hit_status = is_local(paddr, IDX_IRQ_STATUS);
  assign hit_mask = is_local(paddr, IDX_IRQ_MASK);
  assign hit_any = hit_vendor || hit_device || hit_diag || hit_cap_id
                   || hit_cap_link || hit_cap_word || hit_status
                   || hit_mask;

  // Zero-wait slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ==========================================================
  // Global reset pin
  logic global_rst_sync_n;

  pdg_sync u_global_sync (
    .core_clk(core_clk),
    .async_in(global_reset_n),
    .sync_out(global_rst_sync_n)
  );

  // ==========================================================
  // Diagnostic byte storage
  logic id_mask_reg;
  logic dt_disable_reg;
  logic retry_long_reg;
  logic card_sel_reg;
  logic host_sel_reg;
  logic [1:0] chg_route_reg;
  logic [1:0] zv_disable_reg;
  logic [1:0] wake_cold_reg;

  // Shared bits, global reset only, written through function 0
  always_ff @(posedge core_clk) begin
    if (!global_rst_sync_n) begin
      id_mask_reg <= DIAG_RESET[DG_ID_MASK];
      dt_disable_reg <= DIAG_RESET[DG_DT_DIS];
      retry_long_reg <= DIAG_RESET[DG_RETRY_LONG];
      card_sel_reg <= DIAG_RESET[DG_CARD_SEL];
      host_sel_reg <= DIAG_RESET[DG_HOST_SEL];
    end else if (wr_en && hit_diag && !fn1) begin
      id_mask_reg <= pwdata[DG_ID_MASK];
      dt_disable_reg <= pwdata[DG_DT_DIS];
      retry_long_reg <= pwdata[DG_RETRY_LONG];
      card_sel_reg <= pwdata[DG_CARD_SEL];
      host_sel_reg <= pwdata[DG_HOST_SEL];
    end
  end

  // Per-function bits, global reset only
  always_ff @(posedge core_clk) begin
    if (!global_rst_sync_n) begin
      chg_route_reg <= {2{DIAG_RESET[DG_CHG_ROUTE]}};
      zv_disable_reg <= {2{DIAG_RESET[DG_ZV_DIS]}};
    end else if (wr_en && hit_diag) begin
      chg_route_reg[fn1] <= pwdata[DG_CHG_ROUTE];
      zv_disable_reg[fn1] <= pwdata[DG_ZV_DIS];
    end
  end

  // Wake-from-cold-D3 advertisement, the only writable capability bit
  always_ff @(posedge core_clk) begin
    if (!global_rst_sync_n) begin
      wake_cold_reg <= {2{CAP_WORD_RESET[CAP_WAKE_COLD]}};
    end else if (wr_en && hit_cap_word) begin
      wake_cold_reg[fn1] <= pwdata[CAP_WAKE_COLD];
    end
  end

  // ==========================================================
  // Read-back views
  function automatic logic [7:0] diag_view(input logic f);
    diag_view = 8'h00;
    diag_view[DG_ID_MASK] = id_mask_reg;
    diag_view[DG_FIXED_ONE] = 1'b1;
    diag_view[DG_CHG_ROUTE] = chg_route_reg[f];
    diag_view[DG_DT_DIS] = dt_disable_reg;
    diag_view[DG_RETRY_LONG] = retry_long_reg;
    diag_view[DG_CARD_SEL] = card_sel_reg;
    diag_view[DG_HOST_SEL] = host_sel_reg;
    diag_view[DG_ZV_DIS] = zv_disable_reg[f];
  endfunction

  function automatic logic [15:0] cap_view(input logic f);
    // D1/D2 and wake-state bits fixed except wake-from-cold, version 010b
    cap_view = CAP_WORD_RESET;
    cap_view[CAP_WAKE_COLD] = wake_cold_reg[f];
    // Aux-power flag only meaningful while cold wake is offered
    cap_view[CAP_AUX_PWR] = wake_cold_reg[f]
                            && CAP_WORD_RESET[CAP_AUX_PWR];
  endfunction

  // ==========================================================
  // Interrupt status and mask
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear;

  assign irq_set[IRQ_CHG0] = card_change_to_pci[0];
  assign irq_set[IRQ_CHG1] = card_change_to_pci[1];
  assign irq_set[IRQ_CARD_DISCARD] = card_discard_expired;
  assign irq_set[IRQ_HOST_DISCARD] = host_discard_expired;
  assign irq_set[IRQ_RETRY] = retry_terminate;
  assign irq_clear = (wr_en && hit_status) ? pwdata[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (wr_en && hit_mask) begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // Read data, captured in the setup cycle
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_vendor) begin
      rd_mux[15:0] = id_mask_reg ? ID_MASKED : VENDOR_ID;
    end else if (hit_device) begin
      rd_mux[15:0] = id_mask_reg ? ID_MASKED : DEVICE_ID;
    end else if (hit_diag) begin
      rd_mux[7:0] = diag_view(fn1);
    end else if (hit_cap_id) begin
      rd_mux[7:0] = CAP_ID_VALUE;
    end else if (hit_cap_link) begin
      rd_mux[7:0] = CAP_LINK_VALUE;
    end else if (hit_cap_word) begin
      rd_mux[15:0] = cap_view(fn1);
    end else if (hit_status) begin
      rd_mux[IRQ_W-1:0] = irq_status_reg;
    end else if (hit_mask) begin
      rd_mux[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // Card status change routing
  logic [1:0] chg_route_ok;

  assign chg_route_ok[0] = chg_route_reg[0]
                           ? (legacy_socket_regs_805_hi0 == 4'h0)
                           : legacy_socket_regs_803_b4[0];
  assign chg_route_ok[1] = chg_route_reg[1]
                           ? (legacy_socket_regs_805_hi1 == 4'h0)
                           : legacy_socket_regs_803_b4[1];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      card_change_to_pci <= 2'b00;
    end else begin
      card_change_to_pci <= card_change_event & chg_route_ok;
    end
  end

  // ==========================================================
  // Control outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      id_mask_enable <= 1'b0;
      deferred_access_off <= 1'b0;
      long_retry_window <= 1'b0;
      zoomed_video_model_disable <= 2'b00;
    end else begin
      id_mask_enable <= id_mask_reg;
      deferred_access_off <= dt_disable_reg;
      long_retry_window <= retry_long_reg;
      zoomed_video_model_disable <= zv_disable_reg;
    end
  end

  // ==========================================================
  // Retry latency and discard timers
  localparam logic [TMR_W-1:0] DISC_SHORT = TMR_W'(DISCARD_SHORT);
  localparam logic [TMR_W-1:0] DISC_LONG = TMR_W'(DISCARD_LONG);

  logic [TMR_W-1:0] retry_limit;
  logic [TMR_W-1:0] card_limit;
  logic [TMR_W-1:0] host_limit;

  assign retry_limit = retry_long_reg ? RETRY_LONG : RETRY_SHORT;
  assign card_limit = card_sel_reg ? DISC_SHORT : DISC_LONG;
  assign host_limit = host_sel_reg ? DISC_SHORT : DISC_LONG;

  // Host-side clock paces the target retry window
  pdg_timer u_retry_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_en(host_tick_en),
    .run(target_access_active),
    .limit(retry_limit),
    .expired(retry_terminate)
  );

  // Discard timers idle while delayed transactions are off
  pdg_timer u_host_discard (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_en(host_tick_en),
    .run(host_dt_pending && !dt_disable_reg),
    .limit(host_limit),
    .expired(host_discard_expired)
  );

  pdg_timer u_card_discard (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_en(card_tick_en),
    .run(card_dt_pending && !dt_disable_reg),
    .limit(card_limit),
    .expired(card_discard_expired)
  );
endmodule

// [pdg_monitor.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker
module pdg_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Events
  input wire logic host_dt_pending,
  input wire logic card_dt_pending,
  input wire logic [1:0] card_change_event,
  input wire logic [1:0] card_change_to_pci,
  input wire logic retry_terminate,
  input wire logic host_discard_expired,
  input wire logic card_discard_expired,
  input wire logic irq
);
  import pdg_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;

  cap_id_read_a: assert property (
    rd_acc && (paddr & 12'hbff) == 12'h280 |-> prdata == 32'h1)
    else $error("power_cap_list_id read wrong");
  cap_link_read_a: assert property (
    rd_acc && (paddr & 12'hbff) == 12'h284 |-> prdata == 32'h0)
    else $error("capability link read wrong");
  fixed_one_a: assert property (
    rd_acc && (paddr & 12'hbff) == 12'h24c |-> prdata[6])
    else $error("diagnostic bit 6 read as zero");
  cap_version_a: assert property (
    rd_acc && (paddr & 12'hbff) == 12'h288
    |-> prdata[2:0] == 3'b010 && prdata[14:9] == 6'h3f)
    else $error("capability word fixed bits wrong");
  change_route_a: assert property (
    card_change_to_pci[0] |-> $past(card_change_event[0]))
    else $error("card status change routed without event");
  retry_gap_a: assert property (
    retry_terminate |=> !retry_terminate [*8])
    else $error("retry pulses too close");
  host_discard_a: assert property (
    host_discard_expired |-> $past(host_dt_pending))
    else $error("host discard without pending transaction");
  card_discard_a: assert property (
    card_discard_expired |-> $past(card_dt_pending))
    else $error("card discard without pending transaction");
  err_phase_a: assert property (
    pslverr |-> psel && penable && (paddr & 12'hbff) != 12'h24c)
    else $error("error response outside access or on mapped word");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(wr_acc, 2))
    else $error("interrupt dropped without a write");
endmodule

bind pdg_diag_pm_regs pdg_monitor mon_u (.core_clk(core_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .host_dt_pending(host_dt_pending), .card_dt_pending(card_dt_pending),
  .card_change_event(card_change_event),
  .card_change_to_pci(card_change_to_pci),
  .retry_terminate(retry_terminate),
  .host_discard_expired(host_discard_expired),
  .card_discard_expired(card_discard_expired), .irq(irq));

// [testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench top
module testbench;
  import pdg_pkg::*;
  logic core_clk = '0;
  logic rst_n = '0;
  logic global_reset_n = '0;
  logic psel = '0, penable = '0, pwrite = '0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, host_tick_en = '0, card_tick_en = '0;
  logic target_access_active = '0, host_dt_pending = '0;
  logic card_dt_pending = '0;
  logic [1:0] card_change_event = '0, b803 = '0;
  logic [3:0] h805a = '0, h805b = '0;
  logic id_mask_enable, deferred_access_off, long_retry_window;
  logic [1:0] zoomed_video_model_disable, card_change_to_pci;
  logic retry_terminate, host_discard_expired, card_discard_expired, irq;
  int failures = 0;
  int num_checks = 0;
  logic [32:0] exp_q[$];

  pdg_diag_pm_regs #(.DISCARD_SHORT(8), .DISCARD_LONG(64)) dut_u (
    .core_clk, .rst_n, .global_reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .host_tick_en, .card_tick_en,
    .target_access_active, .host_dt_pending, .card_dt_pending,
    .card_change_event,
    .legacy_socket_regs_803_b4(b803), .legacy_socket_regs_805_hi0(h805a),
    .legacy_socket_regs_805_hi1(h805b), .id_mask_enable,
    .deferred_access_off, .long_retry_window, .zoomed_video_model_disable,
    .card_change_to_pci, .retry_terminate, .host_discard_expired,
    .card_discard_expired, .irq);

  always #4 core_clk = ~core_clk;

  task automatic complete_run();
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    num_checks++;
    if (seen !== expv) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, seen, expv);
    end
  endtask

  // ==========================================================
  // APB master; each access notes its expected answer
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge core_clk);
    exp_q.push_back(e);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) begin
      failures++;
      complete_run();
    end else begin
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, '0, {1'h0, e});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 33'h0);
  endtask

  // Answer watcher: oldest note against what the bus returns
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'h1) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end

  task automatic pulse(input logic g);
    @(posedge core_clk);
    rst_n <= 1'h0;
    global_reset_n <= !g;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'h1;
    global_reset_n <= 1'h1;
    repeat (4) @(posedge core_clk);
  endtask

  // Runs one timer; a discard timer with only its own side ticking, the retry timer with both sides ticking
  task automatic measure(input int sel, input int lim);
    int k;
    @(posedge core_clk);
    host_tick_en <= sel != 1;
    card_tick_en <= sel != 0;
    host_dt_pending <= sel == 0;
    card_dt_pending <= sel == 1;
    target_access_active <= sel == 2;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while ((sel == 0 ? host_discard_expired : sel == 1 ?
      card_discard_expired : retry_terminate) !== 1'h1 && k < 2000);
    check(33'(k), 33'(lim));
    // A pulse that never came has been counted; stop here
    if (k >= 2000 && lim < 2000) begin
      complete_run();
    end else begin
      @(posedge core_clk);
      {host_dt_pending, card_dt_pending, target_access_active} <= 3'h0;
    end
  endtask

  task automatic card_change(input int f, input logic [1:0] e);
    @(posedge core_clk);
    card_change_event <= (f != 0) ? 2'b10 : 2'b01;
    @(posedge core_clk);
    card_change_event <= 2'h0;
    #1;
    check(card_change_to_pci, e);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    complete_run();
  end

  initial begin
    void'($urandom(44468));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    global_reset_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    for (int f = 0; f < 2; f++) begin
      rd(12'h24c + 12'(f * 1024), 32'h60);
      rd(12'h280 + 12'(f * 1024), 32'h1);
      rd(12'h284 + 12'(f * 1024), 32'h0);
      rd(12'h288 + 12'(f * 1024), 32'hfe12);
      rd(12'h000 + 12'(f * 1024), 32'h1234);
      rd(12'h008 + 12'(f * 1024), 32'h5678);
    end
    apb(1'h0, 12'h100, '0, 33'h1_0000_0000);
    apb(1'h1, 12'h24d, 32'hff, 33'h1_0000_0000);
    wr(12'h24c, 32'hbf);
    rd(12'h24c, 32'hff);
    check({id_mask_enable, deferred_access_off, long_retry_window,
      zoomed_video_model_disable}, 33'h1d);
    rd(12'h000, 32'hffff);
    rd(12'h008, 32'hffff);
    rd(12'h64c, 32'hfe);
    wr(12'h64c, 32'h01);
    rd(12'h64c, 32'hdf);
    rd(12'h24c, 32'hff);
    check(zoomed_video_model_disable, 33'h3);
    r = $urandom;
    wr(12'h288, r);
    rd(12'h288, r[15] ? 32'hfe12 : 32'h7e02);
    pulse(1'h0);
    rd(12'h24c, 32'hff);
    rd(12'h288, r[15] ? 32'hfe12 : 32'h7e02);
    pulse(1'h1);
    rd(12'h24c, 32'h60);
    rd(12'h64c, 32'h60);
    rd(12'h288, 32'hfe12);
    check({id_mask_enable, deferred_access_off, long_retry_window,
      zoomed_video_model_disable}, 33'h0);
    wr(12'h24c, 32'h20);
    measure(0, 64);
    measure(1, 64);
    measure(2, 16);
    wr(12'h24c, 32'h2e);
    measure(0, 8);
    measure(1, 8);
    measure(2, 64);
    wr(12'h24c, 32'h30);
    measure(0, 2000);
    measure(1, 2000);
    // ==========================================================
    // Interrupt routing, masking and clearing
    wr(12'h24c, 32'h20);
    rd(12'h800, 32'h1c);
    wr(12'h800, 32'h1f);
    wr(12'h804, 32'h0);
    card_change(0, 2'b01);
    repeat (3) @(posedge core_clk);
    check(irq, 33'h0);
    rd(12'h800, 32'h1);
    wr(12'h804, 32'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 33'h1);
    wr(12'h800, 32'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 33'h0);
    rd(12'h800, 32'h0);
    h805a <= 4'h3;
    b803 <= 2'b01;
    card_change(0, 2'b00);
    wr(12'h24c, 32'h0);
    card_change(0, 2'b01);
    b803 <= 2'b00;
    card_change(0, 2'b00);
    card_change(1, 2'b10);
    complete_run();
  end
endmodule
